// >>> rtl/bc_response_validation_retry.v
/*
 * Bus controller response validation and status-driven retry decision.
 * Checks each completed message's status word and data word count, sets
 * block status and condition code flags, and requests a retry when enabled.
 * Assumes a protocol engine that delivers one message summary per done
 * strobe, synchronous to clk_i, and a classic Wishbone master.
 */
// Our own choices: register access over Wishbone and the register offsets.
// Contract
// - Retry-on-status cleared: status word bits never cause a retry.
// - Retry-on-status set: any set status bit with zero mask bit retries.
// - Retry-on-status set: broadcast-received differs from mask bit 5 retries.
// - Retry-on-status set: status address unequal to command address retries.
// - No-data-valid bit, reset zero, governs message-error transmit validation.
// - No-data-valid clear: message error valid only with commanded count; good flags.
// - Wrong count: format errors, masked-status, word count, bad message, status-set.
// - No-data-valid set: commanded count or zero words valid; no good data if zero.
// - Status retries need global retry enable and message retry enable.
`timescale 1ns/1ps
`default_nettype none
`include "bc_retry_consts.vh"

module bc_response_validation_retry #(
	parameter DATA_W = 32
) (
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [DATA_W-1:0] dat_i,
	output wire [DATA_W-1:0] dat_o,
	output wire ack_o,
	input wire msg_done_i,
	input wire is_transmit_i,
	input wire status_rcvd_i,
	input wire [15:0] status_word_i,
	input wire [15:0] cmd_word_i,
	input wire [15:0] ctrl_word_i,
	input wire [5:0] data_count_i,
	output wire result_valid_o,
	output wire retry_req_o,
	output wire good_data_block_flag_o,
	output wire good_transfer_condition_o,
	output wire masked_status_set_flag_o,
	output wire status_set_flag_o,
	output wire format_error_status_o,
	output wire format_error_condition_o,
	output wire word_count_error_flag_o,
	output wire bad_message_condition_o,
	output wire irq_o
);

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	reg [15:0] cfg_ff;
	reg [15:0] smask_ff;
	reg [`RES_W-1:0] result_ff;
	reg [`IRQ_W-1:0] irq_stat_ff;
	reg [`IRQ_W-1:0] irq_mask_ff;
	reg [DATA_W-1:0] rdata_ff;
	reg ack_ff;
	reg valid_ff;
	reg retry_ff;
	reg irq_ff;

	reg [15:0] nxt_cfg;
	reg [15:0] nxt_smask;
	reg [`RES_W-1:0] nxt_result;
	reg [`IRQ_W-1:0] nxt_irq_stat;
	reg [`IRQ_W-1:0] nxt_irq_mask;
	reg [DATA_W-1:0] nxt_rdata;

	wire retry_on_unmasked_status;
	wire msg_error_no_data_valid;
	wire global_retry_enable;
	wire msg_error_mask_ctl;
	wire msg_retry_enable;

	assign global_retry_enable = cfg_ff[`CFG_GLOBAL_RETRY];
	assign retry_on_unmasked_status = cfg_ff[`CFG_RETRY_STATUS];
	assign msg_error_no_data_valid = cfg_ff[`CFG_NO_DATA_VALID];
	assign msg_error_mask_ctl = ctrl_word_i[`CTL_ME_MASK];
	assign msg_retry_enable = ctrl_word_i[`CTL_RETRY_EN];

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	// Merge a 16-bit write under byte lanes 0 and 1 and a writable mask
	function [15:0] merge16;
		input [15:0] old_val;
		input [15:0] wr_val;
		input [1:0] lanes;
		input [15:0] wmask;
		reg [15:0] lane_mask;
		begin
			lane_mask = {{8{lanes[1]}}, {8{lanes[0]}}};
			merge16 = (old_val & ~(lane_mask & wmask)) | (wr_val & lane_mask & wmask);
		end
	endfunction

	// Commanded word count: a zero count field means 32 words
	function [5:0] cmd_count;
		input [15:0] cw;
		begin
			if (cw[`CW_COUNT_HI:`CW_COUNT_LO] == 5'h00) begin
				cmd_count = `COUNT_FULL;
			end else begin
				cmd_count = {1'b0, cw[`CW_COUNT_HI:`CW_COUNT_LO]};
			end
		end
	endfunction

	// Word index of the bus address names the given register
	function reg_hit;
		input [5:0] idx;
		input [5:0] ofs;
		begin
			reg_hit = idx == ofs;
		end
	endfunction

	// ------------------------------------------------------------------------
	// Status-word retry evaluation
	// ------------------------------------------------------------------------
	wire [5:0] unmasked_bits;
	wire bcr_mismatch;
	wire addr_mismatch;
	wire status_retry_cond;
	wire retry_now;

	// Mask bit 14 pairs with status bit 10, down to mask bit 9 with bit 5
	assign unmasked_bits = status_word_i[`SW_FLAG_HI:`SW_FLAG_LO]
		& ~smask_ff[`SMASK_HI:`SMASK_LO];
	assign bcr_mismatch = status_word_i[`SW_BCR] != smask_ff[`SMASK_BCR];
	assign addr_mismatch = status_word_i[`SW_ADDR_HI:`SW_ADDR_LO]
		!= cmd_word_i[`CW_ADDR_HI:`CW_ADDR_LO];
	assign status_retry_cond = status_rcvd_i & retry_on_unmasked_status
		& ((|unmasked_bits) | bcr_mismatch | addr_mismatch);
	assign retry_now = msg_done_i & global_retry_enable & msg_retry_enable
		& status_retry_cond;

	// ------------------------------------------------------------------------
	// Message result evaluation
	// ------------------------------------------------------------------------
	wire me_bit;
	wire me_transmit;
	wire count_ok;
	wire no_data;
	wire me_valid;
	wire fmt_err;
	wire good_data;
	reg [`RES_W-1:0] msg_result;

	assign me_bit = status_rcvd_i & status_word_i[`SW_MSG_ERR];
	assign me_transmit = me_bit & is_transmit_i;
	assign count_ok = data_count_i == cmd_count(cmd_word_i);
	assign no_data = data_count_i == 6'h00;
	// Zero words accepted only when the no-data-valid option is set
	assign me_valid = count_ok | (msg_error_no_data_valid & no_data);
	assign fmt_err = me_transmit ? ~me_valid : (is_transmit_i & ~count_ok);
	// Good data never shown for a zero-word reply
	assign good_data = count_ok & ~no_data & ~fmt_err;

	always @* begin
		msg_result = {`RES_W{1'b0}};
		msg_result[`RES_GOOD_DATA] = good_data;
		msg_result[`RES_GOOD_XFER] = good_data;
		msg_result[`RES_RETRY] = retry_now;
		if (fmt_err) begin
			msg_result[`RES_FMT_BS] = 1'b1;
			msg_result[`RES_FMT_CC] = 1'b1;
			msg_result[`RES_WC_ERR] = 1'b1;
			msg_result[`RES_BAD_MESSAGE_CONDITION] = 1'b1;
			msg_result[`RES_MASKED_STATUS_SET_FLAG] = 1'b1;
			msg_result[`RES_STATUS_SET_FLAG] = 1'b1;
		end else if (me_bit) begin
			if (msg_error_mask_ctl) begin
				msg_result[`RES_MASKED_STATUS_SET_FLAG] = 1'b1;
			end else begin
				msg_result[`RES_STATUS_SET_FLAG] = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------------------
	wire bus_req;
	wire wr_stb;
	wire rd_stb;
	wire [5:0] reg_idx;

	// Answer one cycle after the request; ack falls the next cycle
	assign bus_req = cyc_i & stb_i & ~ack_ff;
	// Writes land at the edge where the master samples ack high
	assign wr_stb = cyc_i & stb_i & we_i & ack_ff;
	assign rd_stb = bus_req & ~we_i;
	assign reg_idx = adr_i[`ADR_HI:`ADR_LO];

	always @* begin
		nxt_rdata = {DATA_W{1'b0}};
		case (reg_idx)
			`OFS_CONFIG: begin
				nxt_rdata[15:0] = cfg_ff;
			end
			`OFS_STAT_MASK: begin
				nxt_rdata[15:0] = smask_ff;
			end
			`OFS_RESULT: begin
				nxt_rdata[`RES_W-1:0] = result_ff;
			end
			`OFS_IRQ_STATUS: begin
				nxt_rdata[`IRQ_W-1:0] = irq_stat_ff;
			end
			`OFS_IRQ_MASK: begin
				nxt_rdata[`IRQ_W-1:0] = irq_mask_ff;
			end
			default: begin
				nxt_rdata = {DATA_W{1'b0}};
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// Register selects
	// ------------------------------------------------------------------------
	wire wr_cfg;
	wire wr_smask;
	wire wr_imask;
	wire rd_istat;

	assign wr_cfg = wr_stb & reg_hit(reg_idx, `OFS_CONFIG);
	assign wr_smask = wr_stb & reg_hit(reg_idx, `OFS_STAT_MASK);
	assign wr_imask = wr_stb & reg_hit(reg_idx, `OFS_IRQ_MASK);
	// Clear taken with the data snapshot, so no event slips in between
	assign rd_istat = rd_stb & reg_hit(reg_idx, `OFS_IRQ_STATUS);

	// ------------------------------------------------------------------------
	// Register next-state logic
	// ------------------------------------------------------------------------
	wire [`IRQ_W-1:0] irq_events;
	wire nxt_irq;

	assign irq_events = {fmt_err & msg_done_i, retry_now, msg_done_i};
	assign nxt_irq = |(nxt_irq_stat & nxt_irq_mask);

	// Configuration register
	always @* begin
		nxt_cfg = cfg_ff;
		if (wr_cfg) begin
			nxt_cfg = merge16(cfg_ff, dat_i[15:0], sel_i[1:0], `CFG_WMASK);
		end
	end

	// Status mask register
	always @* begin
		nxt_smask = smask_ff;
		if (wr_smask) begin
			nxt_smask = merge16(smask_ff, dat_i[15:0], sel_i[1:0], `SMASK_WMASK);
		end
	end

	// Interrupt mask, byte lane 0 only
	always @* begin
		nxt_irq_mask = irq_mask_ff;
		if (wr_imask && sel_i[0]) begin
			nxt_irq_mask = dat_i[`IRQ_W-1:0];
		end
	end

	// Sticky status: new events win over a clearing read
	always @* begin
		nxt_irq_stat = irq_stat_ff;
		if (rd_istat) begin
			nxt_irq_stat = {`IRQ_W{1'b0}};
		end
		nxt_irq_stat = nxt_irq_stat | irq_events;
	end

	// Last message result, held until the next one
	always @* begin
		nxt_result = result_ff;
		if (msg_done_i) begin
			nxt_result = msg_result;
		end
	end

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			cfg_ff <= `CFG_RESET;
			smask_ff <= `SMASK_RESET;
			result_ff <= {`RES_W{1'b0}};
			irq_stat_ff <= {`IRQ_W{1'b0}};
			irq_mask_ff <= {`IRQ_W{1'b0}};
			valid_ff <= 1'b0;
			retry_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else if (ce_i) begin
			cfg_ff <= nxt_cfg;
			smask_ff <= nxt_smask;
			result_ff <= nxt_result;
			irq_stat_ff <= nxt_irq_stat;
			irq_mask_ff <= nxt_irq_mask;
			valid_ff <= msg_done_i;
			retry_ff <= retry_now;
			irq_ff <= nxt_irq;
		end
	end

	// Bus answer flops
	always @(posedge clk_i) begin
		if (rst_i) begin
			rdata_ff <= {DATA_W{1'b0}};
			ack_ff <= 1'b0;
		end else if (ce_i) begin
			rdata_ff <= nxt_rdata;
			ack_ff <= bus_req;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign dat_o = rdata_ff;
	assign ack_o = ack_ff;
	assign result_valid_o = valid_ff;
	assign retry_req_o = retry_ff;
	assign good_data_block_flag_o = result_ff[`RES_GOOD_DATA];
	assign good_transfer_condition_o = result_ff[`RES_GOOD_XFER];
	assign masked_status_set_flag_o = result_ff[`RES_MASKED_STATUS_SET_FLAG];
	assign status_set_flag_o = result_ff[`RES_STATUS_SET_FLAG];
	assign format_error_status_o = result_ff[`RES_FMT_BS];
	assign format_error_condition_o = result_ff[`RES_FMT_CC];
	assign word_count_error_flag_o = result_ff[`RES_WC_ERR];
	assign bad_message_condition_o = result_ff[`RES_BAD_MESSAGE_CONDITION];
	assign irq_o = irq_ff;

endmodule
`default_nettype wire

// >>> rtl/bc_retry_consts.vh
/*
 * Constants for the bus controller response validation and retry block:
 * register offsets, bit positions, field layouts, reset values and event codes.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef BC_RETRY_CONSTS_VH
`define BC_RETRY_CONSTS_VH

// ----------------------------------------------------------------------------
// Register offsets (word index in address bits 7:2)
// ----------------------------------------------------------------------------
`define OFS_CONFIG 6'h00
`define OFS_STAT_MASK 6'h01
`define OFS_RESULT 6'h02
`define OFS_IRQ_STATUS 6'h03
`define OFS_IRQ_MASK 6'h04
`define ADR_HI 7
`define ADR_LO 2

// ----------------------------------------------------------------------------
// Message handling configuration register bits
// ----------------------------------------------------------------------------
`define CFG_GLOBAL_RETRY 12
`define CFG_RETRY_STATUS 8
`define CFG_NO_DATA_VALID 7
`define CFG_RESET 16'h0000
`define CFG_WMASK 16'h1180

// ----------------------------------------------------------------------------
// Status mask register
// ----------------------------------------------------------------------------
`define SMASK_HI 14
`define SMASK_LO 9
`define SMASK_BCR 5
`define SMASK_RESET 16'h0000
`define SMASK_WMASK 16'h7E20

// ----------------------------------------------------------------------------
// Received status word and command word fields
// ----------------------------------------------------------------------------
`define SW_ADDR_HI 15
`define SW_ADDR_LO 11
`define SW_MSG_ERR 10
`define SW_FLAG_HI 10
`define SW_FLAG_LO 5
`define SW_BCR 4
`define CW_ADDR_HI 15
`define CW_ADDR_LO 11
`define CW_COUNT_HI 4
`define CW_COUNT_LO 0
`define COUNT_FULL 6'h20

// ----------------------------------------------------------------------------
// Per-message control word bits
// ----------------------------------------------------------------------------
`define CTL_RETRY_EN 8
`define CTL_ME_MASK 9

// ----------------------------------------------------------------------------
// Result register bits
// ----------------------------------------------------------------------------
`define RES_GOOD_DATA 0
`define RES_GOOD_XFER 1
`define RES_MASKED_STATUS_SET_FLAG 2
`define RES_STATUS_SET_FLAG 3
`define RES_FMT_BS 4
`define RES_FMT_CC 5
`define RES_WC_ERR 6
`define RES_BAD_MESSAGE_CONDITION 7
`define RES_RETRY 8
`define RES_W 9

// ----------------------------------------------------------------------------
// Interrupt events
// ----------------------------------------------------------------------------
`define IRQ_DONE 0
`define IRQ_RETRY 1
`define IRQ_FMT 2
`define IRQ_W 3

`endif

// >>> test/bc_retry_chk.sv
/* Port checker for the response validation and retry block.
   Assumes it is bound onto every instance of that block. */
`timescale 1ns/1ps
`default_nettype none
module bc_retry_chk (
	input wire logic clk_i, rst_i, ce_i, cyc_i, stb_i, ack_o,
	input wire logic msg_done_i, is_transmit_i, result_valid_o, retry_req_o,
	input wire logic good_data_block_flag_o, format_error_status_o,
	input wire logic format_error_condition_o, word_count_error_flag_o,
	input wire logic bad_message_condition_o, masked_status_set_flag_o,
	input wire logic status_set_flag_o,
	input wire logic [15:0] status_word_i, cmd_word_i, ctrl_word_i,
	input wire logic [5:0] data_count_i
);
	wire tk = msg_done_i && ce_i;
	wire [5:0] want = {cmd_word_i[4:0] == 5'h00, cmd_word_i[4:0]};
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_answer: assert property (cyc_i && stb_i && ce_i && !ack_o |=> ack_o)
		else $error("ack missing");
	a_ack_pulse: assert property (ack_o && ce_i |=> !ack_o)
		else $error("ack too long");
	a_valid_next: assert property (tk |=> result_valid_o)
		else $error("result late");
	a_valid_cause: assert property (result_valid_o && $past(ce_i) |-> $past(msg_done_i))
		else $error("result without message");
	a_retry_valid: assert property (retry_req_o |-> result_valid_o)
		else $error("retry without result");
	a_retry_gated: assert property (tk && !ctrl_word_i[8] |=> !retry_req_o)
		else $error("retry not enabled");
	a_good_count: assert property (tk && is_transmit_i && status_word_i[10] &&
		data_count_i != want |=> !good_data_block_flag_o) else $error("good data bad count");
	a_fmt_pair: assert property (format_error_status_o == format_error_condition_o)
		else $error("format flags differ");
	a_fmt_flags: assert property (format_error_status_o |-> word_count_error_flag_o &&
		bad_message_condition_o && masked_status_set_flag_o && status_set_flag_o &&
		!good_data_block_flag_o) else $error("format flag set incomplete");
	a_flags_hold: assert property (!tk |=> $stable(good_data_block_flag_o) &&
		$stable(format_error_status_o)) else $error("flags moved");
	c_retry: cover property (tk ##1 retry_req_o);
	c_fmt: cover property (tk ##1 format_error_status_o);
	c_ack: cover property (ack_o);
endmodule
bind bc_response_validation_retry bc_retry_chk u_chk (.*);
`default_nettype wire

// >>> test/rt_model.sv
/* Remote terminal stand-in: answers one command per go pulse.
   Assumes the bench gives status word and word count with the pulse. */
`timescale 1ns/1ps
`default_nettype none
module rt_model (
	input wire logic clk_i, go_i, tx_i,
	input wire logic [15:0] sw_i,
	input wire logic [5:0] cnt_i,
	output logic done_o, tx_o, rcvd_o,
	output logic [15:0] sw_o,
	output logic [5:0] cnt_o
);
	initial begin
		{done_o, tx_o, rcvd_o, sw_o, cnt_o} = '0;
	end
	// Transmit, status and count lines toggle outside a response so stale values never look valid
	always @(posedge clk_i) begin
		done_o <= go_i;
		rcvd_o <= go_i;
		tx_o <= go_i ? tx_i : ~tx_o;
		sw_o <= go_i ? sw_i : ~sw_o;
		cnt_o <= go_i ? cnt_i : ~cnt_o;
	end
endmodule
`default_nettype wire

// >>> test/tb.sv
/* Self-checking bench for the response validation and retry block.
   Assumes the checker is bound and the block answers per its contract. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 0, rst = 1, ce = 1, cyc = 0, stb = 0, we = 0, go = 0, tx = 0;
	logic [7:0] adr = 0;
	logic [31:0] wdat = 0;
	logic [15:0] sw = 0, cmd = 0, ctrl = 0, q;
	logic [5:0] cnt = 0;
	wire ack, done, ptx, rcvd, valid, irq;
	wire [31:0] rdat;
	wire [15:0] psw;
	wire [5:0] pcnt;
	wire [8:0] res;
	int num_errors = 0, total_checks = 0;
	bc_response_validation_retry dut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h3), .dat_i(wdat), .dat_o(rdat),
		.ack_o(ack), .msg_done_i(done), .is_transmit_i(ptx), .status_rcvd_i(rcvd),
		.status_word_i(psw), .cmd_word_i(cmd), .ctrl_word_i(ctrl), .data_count_i(pcnt),
		.result_valid_o(valid), .retry_req_o(res[8]), .bad_message_condition_o(res[7]),
		.word_count_error_flag_o(res[6]), .format_error_condition_o(res[5]),
		.format_error_status_o(res[4]), .status_set_flag_o(res[3]),
		.masked_status_set_flag_o(res[2]), .good_transfer_condition_o(res[1]),
		.good_data_block_flag_o(res[0]), .irq_o(irq));
	rt_model rt (.clk_i(clk), .go_i(go), .tx_i(tx), .sw_i(sw), .cnt_i(cnt),
		.done_o(done), .tx_o(ptx), .rcvd_o(rcvd), .sw_o(psw), .cnt_o(pcnt));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task test_done;
		if (num_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", n, exp, got);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		int n;
		@(posedge clk);
		cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= {16'h0000, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			num_errors++;
			test_done;
		end
		q = rdat[15:0];
		cyc <= 0; stb <= 0; we <= 0;
	endtask
	task msg(input logic t, input logic [15:0] s, c, k, input logic [5:0] n,
		input logic [8:0] exp, m);
		@(posedge clk);
		go <= 1; tx <= t; sw <= s; cmd <= c; ctrl <= k; cnt <= n;
		@(posedge clk);
		go <= 0;
		@(posedge clk);
		#1 chk("valid", {15'h0000, valid}, 16'h0001);
		chk("result", {7'h00, res & m}, {7'h00, exp});
	endtask
	task t_regs;
		bus(0, 8'h00, 0); chk("config", q, 16'h0000);
		bus(0, 8'h04, 0); chk("smask", q, 16'h0000);
		bus(1, 8'h00, 16'hFFFF); bus(0, 8'h00, 0); chk("config", q, 16'h1180);
		bus(1, 8'h04, 16'hFFFF); bus(0, 8'h04, 0); chk("smask", q, 16'h7E20);
		bus(1, 8'h20, 16'hFFFF); bus(0, 8'h20, 0); chk("hole", q, 16'h0000);
	endtask
	task t_status;
		bus(1, 8'h00, 16'h1100); bus(1, 8'h04, 16'h0000);
		msg(0, 16'h2800, 16'h2805, 16'h0100, 5, 9'h000, 9'h100);
		msg(0, 16'h2A00, 16'h2805, 16'h0100, 5, 9'h100, 9'h100);
		msg(0, 16'h2810, 16'h2805, 16'h0100, 5, 9'h100, 9'h100);
		msg(0, 16'h3000, 16'h2805, 16'h0100, 5, 9'h100, 9'h100);
		bus(1, 8'h04, 16'h7E20);
		msg(0, 16'h2A10, 16'h2805, 16'h0100, 5, 9'h000, 9'h100);
		msg(0, 16'h2800, 16'h2805, 16'h0100, 5, 9'h100, 9'h100);
		bus(1, 8'h00, 16'h1000);
		msg(0, 16'h3210, 16'h2805, 16'h0100, 5, 9'h000, 9'h100);
	endtask
	task t_gate;
		bus(1, 8'h00, 16'h0100); bus(1, 8'h04, 16'h0000);
		msg(0, 16'h3000, 16'h2805, 16'h0100, 5, 9'h000, 9'h100);
		bus(1, 8'h00, 16'h1100);
		msg(0, 16'h3000, 16'h2805, 16'h0000, 5, 9'h000, 9'h100);
	endtask
	task t_me;
		bus(1, 8'h00, 16'h0000);
		msg(1, 16'h2C00, 16'h2805, 16'h0200, 5, 9'h007, 9'h1FF);
		msg(1, 16'h2C00, 16'h2805, 16'h0000, 5, 9'h00B, 9'h1FF);
		msg(1, 16'h2C00, 16'h2800, 16'h0200, 32, 9'h007, 9'h1FF);
		msg(1, 16'h2C00, 16'h2805, 16'h0200, 3, 9'h0FC, 9'h1FF);
		msg(1, 16'h2C00, 16'h2805, 16'h0200, 0, 9'h0FC, 9'h1FF);
		bus(0, 8'h08, 0); chk("result reg", q, 16'h00FC);
		bus(1, 8'h00, 16'h0080);
		msg(1, 16'h2C00, 16'h2805, 16'h0200, 0, 9'h004, 9'h1FF);
		msg(1, 16'h2C00, 16'h2805, 16'h0000, 5, 9'h00B, 9'h1FF);
		msg(1, 16'h2C00, 16'h2805, 16'h0200, 3, 9'h0FC, 9'h1FF);
	endtask
	task t_ce;
		@(posedge clk);
		ce <= 0; go <= 1; tx <= 1; sw <= 16'h2C00; ctrl <= 16'h0000; cnt <= 6'h05;
		@(posedge clk);
		go <= 0;
		repeat (2) @(posedge clk);
		#1 chk("frozen valid", {15'h0000, valid}, 16'h0000);
		chk("frozen result", {7'h00, res}, 16'h00FC);
		@(posedge clk);
		ce <= 1;
		msg(1, 16'h2C00, 16'h2805, 16'h0000, 5, 9'h00B, 9'h1FF);
	endtask
	task t_irq;
		bus(1, 8'h10, 16'h0000); bus(0, 8'h0C, 0);
		chk("irq events", q, 16'h0007);
		msg(0, 16'h2800, 16'h2805, 16'h0000, 5, 9'h000, 9'h100);
		chk("irq masked", {15'h0000, irq}, 16'h0000);
		bus(1, 8'h10, 16'h0001);
		@(posedge clk);
		#1 chk("irq", {15'h0000, irq}, 16'h0001);
		bus(0, 8'h0C, 0); chk("irq status", q, 16'h0001);
		@(posedge clk);
		#1 chk("irq cleared", {15'h0000, irq}, 16'h0000);
	endtask
	initial begin
		#200000 num_errors++;
		test_done;
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		t_regs; t_status; t_gate; t_me; t_ce; t_irq;
		test_done;
	end
endmodule
`default_nettype wire
